// ==== rtl/iex_expander.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "iex_consts.svh"

module iex_expander
  import iex_pkg::*;
(
  input  wire logic       core_clk,          // Core clock, 10 MHz
  input  wire logic       reset_n,           // Asynchronous reset, active low
  input  wire logic       scl_clk,           // Bus clock from master
  input  wire logic       sda_i,             // Bus data level
  output logic            sda_o,             // Bus data drive value
  output logic            sda_oe,            // Bus data pull-down enable
  input  wire logic       addr_sel,          // Address-select pin
  input  wire logic [7:0] port_pin_i,        // Port pin levels
  output logic      [7:0] port_pin_o,        // Port pin drive value
  output logic      [7:0] port_pin_oe,       // Port pin drive enable
  output logic      [7:0] high_side_driver,  // High-side driver on
  output logic      [7:0] low_side_driver,   // Low-side driver on
  output logic            alert_n_o,         // Change alert drive value
  output logic            alert_n_oe         // Change alert pull-down enable
);

  // ***********************************************************
  // Reset synchroniser
  // ***********************************************************
  logic [1:0] rst_pipe_q;
  logic       rst_n_q;

  // Release through two flops, assertion stays immediate
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_pipe_q[1];

  // ***********************************************************
  // Start and stop detection on data edges
  // ***********************************************************
  logic start_tog_q;
  logic stop_tog_q;
  logic start_seen_q;
  logic stop_seen_q;
  logic new_frame;
  logic stop_pend;

  // Falling data with clock high marks a start
  always_ff @(negedge sda_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_tog_q <= 1'b0;
    end else if (scl_clk) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // Rising data with clock high marks a stop
  always_ff @(posedge sda_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stop_tog_q <= 1'b0;
    end else if (scl_clk) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // Pending markers until the next bus clock edge absorbs them
  assign new_frame = start_tog_q ^ start_seen_q;
  assign stop_pend = stop_tog_q ^ stop_seen_q;

  // ***********************************************************
  // Link domain: sampling and byte framing
  // ***********************************************************
  iex_state_e state_q;
  iex_state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  iex_byte_t  shift_q;
  iex_byte_t  pin_meta_l_q;
  iex_byte_t  pin_sync_l_q;
  logic       addr_meta_q;
  logic       addr_sync_q;
  logic       ack_slot;
  logic       addr_match;

  // Pins and strap resynchronised on the bus clock
  always_ff @(posedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_l_q <= 8'h00;
      pin_sync_l_q <= 8'h00;
      addr_meta_q  <= 1'b0;
      addr_sync_q  <= 1'b0;
    end else begin
      pin_meta_l_q <= port_pin_i;
      pin_sync_l_q <= pin_meta_l_q;
      addr_meta_q  <= addr_sel;
      addr_sync_q  <= addr_meta_q;
    end
  end

  assign ack_slot   = (cnt_q == `IEX_ACK_SLOT);
  assign addr_match = (shift_q[7:1] == {`IEX_ADDR_BASE, addr_sync_q});

  // Next state; start always wins, ack slot closes each byte
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (new_frame) begin
      state_d = st_addr;
      cnt_d   = 4'h1;
    end else if (state_q != st_idle) begin
      if (!ack_slot) begin
        cnt_d = cnt_q + 4'h1;
      end else begin
        cnt_d = 4'h0;
        case (state_q)
          st_addr: begin
            if (!addr_match) begin
              state_d = st_idle;
            end else if (shift_q[0]) begin
              state_d = st_rdata;
            end else begin
              state_d = st_cmd;
            end
          end
          st_cmd:   state_d = st_wdata;
          st_wdata: state_d = st_wdata;
          st_rdata: state_d = sda_i ? st_idle : st_rdata;
          default:  state_d = st_idle;
        endcase
      end
    end
  end

  // Bit counter, state and marker bookkeeping
  always_ff @(posedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q      <= st_idle;
      cnt_q        <= 4'h0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      start_seen_q <= start_tog_q;
      stop_seen_q  <= stop_tog_q;
    end
  end

  // Shift in MSB first; hold through the ack slot
  always_ff @(posedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_q <= 8'h00;
    end else if (new_frame || !ack_slot) begin
      shift_q <= {shift_q[6:0], sda_i};
    end
  end

  // ***********************************************************
  // Link domain: register file
  // ***********************************************************
  iex_byte_t ptr_q;
  iex_byte_t out_q;
  iex_byte_t inv_q;
  iex_byte_t dir_q;
  iex_byte_t rd_val;
  iex_byte_t in_view;
  logic      cmd_commit;
  logic      wr_commit;
  logic      wr_out;
  logic      wr_inv;
  logic      wr_dir;

  // Commit strobes fire on the ack edge of a written byte
  assign cmd_commit = !new_frame && ack_slot && (state_q == st_cmd);
  assign wr_commit  = !new_frame && ack_slot && (state_q == st_wdata);
  assign wr_out     = wr_commit && (ptr_q[1:0] == `IEX_REG_OUTPUT);
  assign wr_inv     = wr_commit && (ptr_q[1:0] == `IEX_REG_INVERT);
  assign wr_dir     = wr_commit && (ptr_q[1:0] == `IEX_REG_DIR);

  // Pointer survives across frames so reads may skip the command
  always_ff @(posedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_q <= `IEX_PTR_RST;
    end else if (cmd_commit) begin
      ptr_q <= shift_q;
    end
  end

  // Writable registers; bit n belongs to pin n
  always_ff @(posedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_q <= `IEX_OUT_RST;
      inv_q <= `IEX_INV_RST;
      dir_q <= `IEX_DIR_RST;
    end else begin
      out_q <= wr_out ? shift_q : out_q;
      inv_q <= wr_inv ? shift_q : inv_q;
      dir_q <= wr_dir ? shift_q : dir_q;
    end
  end

  // Inversion only applies where the pin is an input
  assign in_view = pin_sync_l_q ^ (inv_q & dir_q);

  // Read mux; output register returns the latch, not the pins
  assign rd_val = (ptr_q[1:0] == `IEX_REG_INPUT)  ? in_view :
                  (ptr_q[1:0] == `IEX_REG_OUTPUT) ? out_q   :
                  (ptr_q[1:0] == `IEX_REG_INVERT) ? inv_q   : dir_q;

  // ***********************************************************
  // Link domain: data drive on the falling bus clock
  // ***********************************************************
  iex_byte_t tx_q;
  iex_byte_t raw_q;
  logic      sda_low_q;
  logic      rd_drive;
  logic      ack_drive;
  logic      tx_bit;

  assign rd_drive  = (state_q == st_rdata) && !ack_slot;
  assign ack_drive = ack_slot && (((state_q == st_addr) && addr_match) ||
                                  (state_q == st_cmd) || (state_q == st_wdata));
  assign tx_bit    = (cnt_q == 4'h0) ? rd_val[7] : tx_q[3'(3'd7 - cnt_q[2:0])];

  // Changes only while the clock is low; released outside slots
  always_ff @(negedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sda_low_q <= 1'b0;
    end else begin
      sda_low_q <= ack_drive | (rd_drive & ~tx_bit);
    end
  end

  // Byte to send is frozen at its first bit
  always_ff @(negedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_q  <= 8'h00;
      raw_q <= 8'h00;
    end else if (rd_drive && (cnt_q == 4'h0)) begin
      tx_q  <= rd_val;
      raw_q <= pin_sync_l_q;
    end
  end

  // Start or stop releases the line at once, not at the next edge
  assign sda_o  = 1'b0;
  assign sda_oe = sda_low_q & ~stop_pend & ~new_frame;

  // ***********************************************************
  // Link domain: input-read event for the alert
  // ***********************************************************
  iex_byte_t snap_l_q;
  logic      rd_tog_q;
  logic      rd_evt;

  assign rd_evt = !new_frame && ack_slot && (state_q == st_rdata) &&
                  (ptr_q[1:0] == `IEX_REG_INPUT);

  // Snapshot held stable for at least nine bus clocks after the toggle
  always_ff @(posedge scl_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      snap_l_q <= 8'h00;
      rd_tog_q <= 1'b0;
    end else if (rd_evt) begin
      snap_l_q <= raw_q;
      rd_tog_q <= ~rd_tog_q;
    end
  end

  // ***********************************************************
  // Core domain: crossings
  // ***********************************************************
  iex_byte_t dir_meta_q;
  iex_byte_t dir_sync_q;
  iex_byte_t out_meta_q;
  iex_byte_t out_sync_q;
  iex_byte_t pin_meta_q;
  iex_byte_t pin_sync_q;
  logic      tog_meta_q;
  logic      tog_sync_q;
  logic      tog_seen_q;

  // Per-bit level crossings; a pin may lag a neighbour by a cycle
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dir_meta_q <= `IEX_DIR_RST;
      dir_sync_q <= `IEX_DIR_RST;
      out_meta_q <= `IEX_OUT_RST;
      out_sync_q <= `IEX_OUT_RST;
    end else begin
      dir_meta_q <= dir_q;
      dir_sync_q <= dir_meta_q;
      out_meta_q <= out_q;
      out_sync_q <= out_meta_q;
    end
  end

  // Pins keep sampling through reset; a cleared pipe would fake a change at release
  always_ff @(posedge core_clk) begin
    pin_meta_q <= port_pin_i;
    pin_sync_q <= pin_meta_q;
  end

  // Toggle crossing for the read event
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_seen_q <= 1'b0;
    end else begin
      tog_meta_q <= rd_tog_q;
      tog_sync_q <= tog_meta_q;
      tog_seen_q <= tog_sync_q;
    end
  end

  // ***********************************************************
  // Core domain: pin drivers and change alert
  // ***********************************************************
  iex_byte_t hs_q;
  iex_byte_t ls_q;
  iex_byte_t snap_q;
  logic      snap_ok_q;
  logic      alert_q;
  logic      rd_seen;
  logic      changed;

  // Direction 1 turns both drivers off; 0 picks one by the latch
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hs_q <= 8'h00;
      ls_q <= 8'h00;
    end else begin
      hs_q <= ~dir_sync_q & out_sync_q;
      ls_q <= ~dir_sync_q & ~out_sync_q;
    end
  end

  assign high_side_driver = hs_q;
  assign low_side_driver  = ls_q;
  assign port_pin_o       = hs_q;
  assign port_pin_oe      = hs_q | ls_q;

  assign rd_seen = tog_sync_q ^ tog_seen_q;
  assign changed = |((pin_sync_q ^ snap_q) & dir_sync_q);

  // First cycle after reset takes the pins as the read reference
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      snap_q    <= 8'h00;
      snap_ok_q <= 1'b0;
    end else if (!snap_ok_q) begin
      snap_q    <= pin_sync_q;
      snap_ok_q <= 1'b1;
    end else if (rd_seen) begin
      snap_q    <= snap_l_q;
    end
  end

  // Alert follows mismatch on input pins only
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= snap_ok_q && changed;
    end
  end

  assign alert_n_o  = 1'b0;
  assign alert_n_oe = alert_q;

  // ***********************************************************
  // Checks
  // ***********************************************************
  start_addr_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    new_frame |=> (state_q == st_addr) && (cnt_q == 4'h1))
    else $error("start did not open address phase");

  addr_ack_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    (!new_frame && ack_slot && state_q == st_addr && addr_match) |-> sda_low_q)
    else $error("matching address not acknowledged");

  addr_ignore_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    (!new_frame && ack_slot && state_q == st_addr && !addr_match) |-> !sda_low_q ##1 state_q == st_idle)
    else $error("foreign address acknowledged");

  byte_ack_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    (!new_frame && ack_slot && (state_q == st_cmd || state_q == st_wdata)) |-> sda_low_q)
    else $error("written byte not acknowledged");

  ptr_load_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    cmd_commit |=> (ptr_q == $past(shift_q)) && (state_q == st_wdata))
    else $error("command byte not stored");

  latch_commit_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    (wr_commit && ptr_q[1:0] == `IEX_REG_OUTPUT) |=> out_q == $past(shift_q))
    else $error("output latch write lost");

  input_ro_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    (wr_commit && ptr_q[1:0] == `IEX_REG_INPUT) |=> $stable(out_q) && $stable(inv_q) && $stable(dir_q))
    else $error("write to input register changed state");

  nack_release_a: assert property (@(posedge scl_clk) disable iff (!rst_n_q)
    (!new_frame && ack_slot && state_q == st_rdata && sda_i) |=> state_q == st_idle ##1 !sda_low_q)
    else $error("data line held after not-acknowledge");

  drivers_off_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    ##1 ((hs_q | ls_q) & $past(dir_sync_q)) == 8'h00)
    else $error("driver on for an input pin");

  reset_dflt_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(rst_n_q) |-> (dir_sync_q == `IEX_DIR_RST) && (port_pin_oe == 8'h00) ##2 !alert_q)
    else $error("reset defaults wrong");

  out_no_alert_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    (dir_sync_q == 8'h00) |=> !alert_q)
    else $error("alert raised by output pins");

  read_cov_c: cover property (@(posedge scl_clk) disable iff (!rst_n_q) rd_evt);
  write_cov_c: cover property (@(posedge scl_clk) disable iff (!rst_n_q) wr_out);
  alert_cov_c: cover property (@(posedge core_clk) disable iff (!rst_n_q) $rose(alert_q) ##[1:400] !alert_q);

endmodule

`default_nettype wire

// ==== rtl/iex_consts.svh ====
`ifndef IEX_CONSTS_SVH
`define IEX_CONSTS_SVH

// ***********************************************************
// Bus address, register selectors and reset values
// ***********************************************************
`define IEX_ADDR_BASE  6'h10
`define IEX_REG_INPUT  2'h0
`define IEX_REG_OUTPUT 2'h1
`define IEX_REG_INVERT 2'h2
`define IEX_REG_DIR    2'h3
`define IEX_OUT_RST    8'hff
`define IEX_INV_RST    8'h00
`define IEX_DIR_RST    8'hff
`define IEX_PTR_RST    8'h00
`define IEX_ACK_SLOT   4'h8

`endif

// ==== rtl/iex_pkg.sv ====
package iex_pkg;

  // ***********************************************************
  // Link state and data types
  // ***********************************************************
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_cmd,
    st_wdata,
    st_rdata
  } iex_state_e;

  typedef logic [7:0] iex_byte_t;

endpackage

// ==== verif/iex_bus_master.sv ====
`timescale 1ns/1ns
`default_nettype none

// ***********************************************************
// Bus master model: bit-banged frames, 64 ns bus period
// ***********************************************************
module iex_bus_master (
  output logic      scl_clk,  // Bus clock, stands high outside frames
  output logic      sda_pull, // High while the master pulls data low
  input  wire logic sda_i     // Resolved data level
);
  localparam int QTR = 16; // Quarter of the bus period

  // Idle bus: clock driven high, data released so the pull-up holds it high
  initial begin
    scl_clk  = 1'b1;
    sda_pull = 1'b0;
  end

  // Start from idle, or a repeated start from the low phase
  task automatic start_c();
    if (scl_clk === 1'b0) begin
      sda_pull = 1'b0;
      #QTR scl_clk = 1'b1;
      #QTR;
    end
    sda_pull = 1'b1;
    #QTR scl_clk = 1'b0;
    #QTR;
  endtask

  // Data low under a high clock, then released: bus back to idle
  task automatic stop_c();
    sda_pull = 1'b1;
    #QTR scl_clk = 1'b1;
    #QTR sda_pull = 1'b0;
    #(2*QTR);
  endtask

  // One clock pulse; data moves only while the clock is low
  task automatic put_bit(input logic b, output logic got);
    sda_pull = ~b;
    #QTR scl_clk = 1'b1;
    #QTR got = sda_i;
    #QTR scl_clk = 1'b0;
    #QTR;
  endtask

  // Eight bits first-to-last from the top, then the acknowledge slot
  task automatic send(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(b[i], g);
    put_bit(1'b1, g);
    ack = ~g;
  endtask

  // Receive a byte; acknowledge unless it is the last one
  task automatic recv(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      b[i] = g;
    end
    put_bit(last, g);
  endtask

  // Write frame: address, pointer byte, one data byte
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic [2:0] acks);
    start_c();
    send({dev, 1'b0}, acks[2]);
    send(ptr, acks[1]);
    send(d, acks[0]);
    stop_c();
  endtask

  // Read frame, optionally after a pointer write and repeated start
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input logic set_ptr,
                    output logic [7:0] d, output logic ack);
    logic a;
    start_c();
    if (set_ptr) begin
      send({dev, 1'b0}, a);
      send(ptr, a);
      start_c();
    end
    send({dev, 1'b1}, ack);
    recv(1'b1, d);
    stop_c();
  endtask
endmodule

`default_nettype wire

// ==== verif/i2c_eight_bit_io_expander_test.sv ====
`timescale 1ns/1ns
`default_nettype none

module i2c_eight_bit_io_expander_test;
  // ***********************************************************
  // Environment: clock, reset, pins and open-drain bus
  // ***********************************************************
  logic       core_clk  = 1'b0;
  logic       reset_n   = 1'b0;
  logic       addr_sel  = 1'b0;
  logic [7:0] pin_ext   = 8'h00;
  logic [6:0] dev       = 7'h20;
  logic       scl_clk;
  logic       sda_pull;
  logic       sda_o;
  logic       sda_oe;
  logic [7:0] port_pin_o;
  logic [7:0] port_pin_oe;
  logic [7:0] high_side_driver;
  logic [7:0] low_side_driver;
  logic       alert_n_oe;
  logic       alert_n_o;
  int         err_count = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  wire        sda_i;
  wire  [7:0] port_pin_i;

  // Pull-up on data; driven pins show their own drive, others the outside level
  assign sda_i      = ~(sda_pull | (sda_oe & ~sda_o));
  assign port_pin_i = (port_pin_oe & port_pin_o) | (~port_pin_oe & pin_ext);

  always #50 core_clk = ~core_clk;

  iex_expander dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel), .port_pin_i(port_pin_i),
    .port_pin_o(port_pin_o), .port_pin_oe(port_pin_oe), .high_side_driver(high_side_driver),
    .low_side_driver(low_side_driver), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe));

  iex_bus_master master_u (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_i(sda_i));

  // ***********************************************************
  // Compare and access helpers
  // ***********************************************************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  // Pin path needs 3-4 core cycles; sample on the falling edge to avoid races
  task automatic settle();
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic set_pins(input logic [7:0] v);
    @(posedge core_clk);
    pin_ext <= v;
    settle();
  endtask

  task automatic wreg(input logic [7:0] ptr, input logic [7:0] d);
    logic [2:0] acks;
    master_u.wr(dev, ptr, d, acks);
    chk_byte({5'h00, acks}, 8'h07, "write acks");
    settle();
  endtask

  task automatic rreg(input logic [7:0] ptr, input logic [7:0] exp, input logic set_ptr);
    logic [7:0] d;
    logic       ack;
    master_u.rd(dev, ptr, set_ptr, d, ack);
    chk_bit(ack, 1'b1, "read address ack");
    chk_byte(d, exp, "read data");
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic test_reset();
    rreg(8'h01, 8'hff, 1'b1);
    rreg(8'h02, 8'h00, 1'b1);
    rreg(8'h03, 8'hff, 1'b1);
    settle();
    chk_byte(port_pin_oe, 8'h00, "enables after reset");
    chk_byte(high_side_driver | low_side_driver, 8'h00, "drivers after reset");
    chk_bit(alert_n_oe, 1'b0, "alert after reset");
    chk_bit(alert_n_o, 1'b0, "alert drive level");
    $display("test reset defaults done");
  endtask

  task automatic test_drive();
    wreg(8'h01, 8'ha5);
    wreg(8'h03, 8'h0f);
    set_pins(8'h5a);
    chk_byte(port_pin_oe, 8'hf0, "drive enables");
    chk_byte(high_side_driver, 8'ha0, "high side");
    chk_byte(low_side_driver, 8'h50, "low side");
    rreg(8'h01, 8'ha5, 1'b1);
    rreg(8'h00, 8'haa, 1'b1);
    $display("test pin drive done");
  endtask

  task automatic test_invert();
    wreg(8'h02, 8'h3c);
    set_pins(8'h96);
    rreg(8'h00, 8'haa, 1'b1);
    wreg(8'h00, 8'h55);
    rreg(8'h00, 8'haa, 1'b0);
    rreg(8'h02, 8'h3c, 1'b1);
    rreg(8'h02, 8'h3c, 1'b0);
    $display("test invert and pointer done");
  endtask

  task automatic test_address();
    logic [2:0] acks;
    master_u.wr(7'h22, 8'h01, 8'h00, acks);
    chk_byte({5'h00, acks}, 8'h00, "foreign address acks");
    @(posedge core_clk);
    addr_sel <= 1'b1;
    dev = 7'h21;
    settle();
    wreg(8'h01, 8'h33);
    rreg(8'h01, 8'h33, 1'b1);
    master_u.wr(7'h20, 8'h01, 8'h00, acks);
    chk_byte({5'h00, acks}, 8'h00, "old address acks");
    @(posedge core_clk);
    addr_sel <= 1'b0;
    dev = 7'h20;
    settle();
    rreg(8'h01, 8'h33, 1'b1);
    $display("test addressing done");
  endtask

  task automatic test_multi();
    logic       a0, a1, a2, a3, a4;
    logic [7:0] d0, d1;
    master_u.start_c();
    master_u.send({dev, 1'b0}, a0);
    master_u.send(8'h01, a1);
    master_u.send(8'h11, a2);
    master_u.send(8'h22, a3);
    master_u.send(8'h3c, a4);
    master_u.stop_c();
    chk_byte({3'h0, a0, a1, a2, a3, a4}, 8'h1f, "multi byte acks");
    settle();
    chk_byte(high_side_driver, 8'h30, "last byte drives");
    rreg(8'h01, 8'h3c, 1'b1);
    master_u.start_c();
    master_u.send({dev, 1'b1}, a0);
    master_u.recv(1'b0, d0);
    master_u.recv(1'b1, d1);
    master_u.stop_c();
    chk_bit(a0, 1'b1, "two byte read ack");
    chk_byte(d0, 8'h3c, "first of two reads");
    chk_byte(d1, 8'h3c, "second of two reads");
    $display("test multi byte write done");
  endtask

  // Outputs moving must stay silent; only input pins raise the alert
  task automatic test_alert();
    rreg(8'h00, 8'h3a, 1'b1);
    settle();
    chk_bit(alert_n_oe, 1'b0, "alert idle");
    wreg(8'h01, 8'hc3);
    chk_bit(alert_n_oe, 1'b0, "output change");
    set_pins(8'h97);
    chk_bit(alert_n_oe, 1'b1, "input change");
    set_pins(8'h96);
    chk_bit(alert_n_oe, 1'b0, "input returns");
    set_pins(8'h92);
    chk_bit(alert_n_oe, 1'b1, "second change");
    rreg(8'h00, 8'hce, 1'b1);
    settle();
    chk_bit(alert_n_oe, 1'b0, "cleared by read");
    wreg(8'h03, 8'h00);
    set_pins(8'h6d);
    chk_byte(port_pin_oe, 8'hff, "all outputs");
    chk_bit(alert_n_oe, 1'b0, "outputs only");
    $display("test change alert done");
  endtask

  task automatic test_reset_mid();
    @(posedge core_clk);
    reset_n <= 1'b0;
    settle();
    chk_byte(port_pin_oe, 8'h00, "enables in reset");
    @(posedge core_clk);
    reset_n <= 1'b1;
    settle();
    test_reset();
    $display("test mid-run reset done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run takes about 800 core cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    settle();
    test_reset();
    test_drive();
    test_invert();
    test_address();
    test_multi();
    test_alert();
    test_reset_mid();
    tally_and_finish();
  end
endmodule

`default_nettype wire
